// file: rfct_toggle.sv
// Feature-configuration toggle command interpreter with reply generation
module rfct_toggle
   import rfct_pkg::*;
#(
   parameter int REPLY_LIMIT = REPLY_LIMIT_CYC,
   parameter int BIT_PERIOD = BIT_CYC,
   parameter logic [7:0] ERR_CODE = 8'h0F
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic rx_frame_start,
   input wire logic rx_frame_sync,
   input wire logic rx_bit,
   input wire logic rx_bit_valid,
   input wire logic rx_frame_end,
   input wire rfct_tag_state_type tag_state,
   input wire logic handle_granted,
   input wire logic [15:0] handle,
   input wire logic [15:0] rn16,
   input wire logic access_pwd_zero,
   input wire logic epc_locked,
   input wire logic tamper_in,
   input wire logic ext_supply_in,
   input wire logic nvm_load,
   input wire logic [15:0] nvm_word,
   input wire logic mem_wr_en,
   input wire logic [11:0] mem_wr_addr,
   input wire logic [15:0] mem_wr_data,
   input wire logic nvm_store_done,
   input wire logic nvm_store_fail,
   output logic nvm_store_req,
   output logic [15:0] nvm_store_data,
   output logic go_arbitrate,
   output logic tx_bit,
   output logic tx_strobe,
   output logic tx_active,
   output logic tx_ext_preamble,
   output logic tx_error,
   output logic [15:0] cfg_word
);
   // ***************************************
   // State and storage
   // ***************************************
   rfct_fsm_type state_q, state_d;
   logic [CMD_BITS-1:0] rx_sr_q;
   logic [6:0] rx_cnt_q;
   logic fsync_q;
   logic [15:0] temp_q, perm_q;
   logic [15:0] pend_q;
   logic [31:0] wait_q;
   logic [15:0] bit_div_q;
   logic bit_en;
   logic reply_ok_q;
   logic go_arb_q;
   logic store_req_q;
   logic [15:0] cfg_q;
   logic load_q;
   logic [PAYLOAD_W-1:0] payload_q;
   logic [5:0] len_q;
   logic [15:0] rx_crc, tx_crc;
   logic tx_busy, tx_feed, tx_done;

   // ***************************************
   // Field decode
   // ***************************************
   logic [15:0] f_opc, f_data, f_handle, mask, apply, eff_mask;
   logic [7:0] f_rfu;
   logic frame_ok, crc_ok, handle_ok, cmd_valid, rfu_hit, act_state;
   logic to_arb, can_toggle, need_store, std_wr, cfg_hit;

   assign f_opc = rx_sr_q[OPC_LSB +: 16];
   assign f_rfu = rx_sr_q[RFU_LSB +: 8];
   assign f_data = rx_sr_q[DATA_LSB +: 16];
   assign f_handle = rx_sr_q[HANDLE_LSB +: 16];
   // Reserved command field is carried but not judged
   assign frame_ok = (rx_cnt_q == CMD_BITS_W) && (f_opc == CMD_CODE) && fsync_q;
   assign crc_ok = (rx_crc == CRC_RESIDUE);
   assign handle_ok = handle_granted && (f_handle == handle);
   assign act_state = (tag_state == TAG_OPEN) || (tag_state == TAG_SECURED);
   assign to_arb = (tag_state == TAG_ARBITRATE) || (tag_state == TAG_REPLY)
      || (tag_state == TAG_ACKNOWLEDGED);
   assign cmd_valid = frame_ok && act_state && crc_ok && handle_ok;
   assign mask = f_data ^ rn16;
   assign rfu_hit = |(mask & RFU_MASK);
   // Zero password suppresses toggling; the enabling reading is not taken
   assign can_toggle = (tag_state == TAG_SECURED) && !access_pwd_zero;
   assign eff_mask = mask & (TEMP_MASK | PERM_MASK);
   assign apply = can_toggle ? eff_mask : 16'h0000;
   assign need_store = |(apply & PERM_MASK);
   assign cfg_hit = (mem_wr_addr == CFG_BIT_ADDR);
   assign std_wr = mem_wr_en && cfg_hit && !epc_locked && (state_q != ST_STORE);

   // ***************************************
   // Bit-rate enable for the reply
   // ***************************************
   assign bit_en = (bit_div_q == 16'h0000);

   always_ff @(posedge clock) begin
      if (rst || bit_div_q == 16'h0000) begin
         bit_div_q <= 16'(BIT_PERIOD - 1);
      end else begin
         bit_div_q <= bit_div_q - 16'h0001;
      end
   end

   // ***************************************
   // Sequencer
   // ***************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (rx_frame_start) begin
               state_d = ST_RECV;
            end
         end
         ST_RECV: begin
            if (rx_frame_end) begin
               state_d = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (!cmd_valid || rfu_hit) begin
               state_d = ST_IDLE;
            end else if (need_store) begin
               state_d = ST_STORE;
            end else begin
               state_d = ST_REPLY;
            end
         end
         ST_STORE: begin
            if (nvm_store_done || nvm_store_fail || wait_q == 32'(REPLY_LIMIT - 1)) begin
               state_d = ST_REPLY;
            end
         end
         ST_REPLY: begin
            if (tx_done) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ***************************************
   // Receive shifter
   // ***************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_sr_q <= '0;
         rx_cnt_q <= 7'h00;
         fsync_q <= 1'b0;
      end else if (state_q == ST_IDLE && rx_frame_start) begin
         rx_cnt_q <= 7'h00;
         fsync_q <= rx_frame_sync;
      end else if (state_q == ST_RECV && rx_bit_valid) begin
         rx_sr_q <= {rx_sr_q[CMD_BITS-2:0], rx_bit};
         // Saturate so an overlong frame never matches the length
         if (rx_cnt_q != 7'h7F) begin
            rx_cnt_q <= rx_cnt_q + 7'h01;
         end
      end
   end

   // ***************************************
   // Configuration bits
   // ***************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         temp_q <= CFG_RESET;
         perm_q <= CFG_RESET;
         pend_q <= 16'h0000;
         store_req_q <= 1'b0;
         nvm_store_data <= 16'h0000;
      end else begin
         store_req_q <= 1'b0;
         if (nvm_load) begin
            perm_q <= nvm_word & PERM_MASK;
         end
         if (std_wr) begin
            temp_q <= mem_wr_data & TEMP_MASK;
            perm_q <= mem_wr_data & PERM_MASK;
            store_req_q <= 1'b1;
            nvm_store_data <= mem_wr_data & PERM_MASK;
         end else if (state_q == ST_CHECK && cmd_valid && !rfu_hit) begin
            temp_q <= temp_q ^ (apply & TEMP_MASK);
            if (need_store) begin
               pend_q <= perm_q ^ (apply & PERM_MASK);
               store_req_q <= 1'b1;
               nvm_store_data <= perm_q ^ (apply & PERM_MASK);
            end
         end else if (state_q == ST_STORE && nvm_store_done) begin
            perm_q <= pend_q;
         end
      end
   end

   assign nvm_store_req = store_req_q;

   always_ff @(posedge clock) begin
      if (rst || state_q != ST_STORE) begin
         wait_q <= 32'h00000000;
      end else begin
         wait_q <= wait_q + 32'h00000001;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_q <= CFG_RESET;
      end else begin
         cfg_q <= temp_q | perm_q;
         cfg_q[TAMPER_POS] <= tamper_in;
         cfg_q[SUPPLY_POS] <= ext_supply_in;
      end
   end

   assign cfg_word = cfg_q;

   // ***************************************
   // Reply launch
   // ***************************************
   logic store_fail, launch_ok, launch_err;
   logic [15:0] new_word;

   assign store_fail = state_q == ST_STORE && !nvm_store_done
      && (nvm_store_fail || wait_q == 32'(REPLY_LIMIT - 1));
   assign launch_ok = (state_q == ST_CHECK && state_d == ST_REPLY)
      || (state_q == ST_STORE && nvm_store_done);
   assign launch_err = store_fail;
   // Word as it stands after this command, indicators live
   assign new_word = (launch_ok && state_q == ST_STORE)
      ? ((temp_q | pend_q) & ~IND_MASK) | (cfg_q & IND_MASK)
      : ((temp_q ^ (apply & TEMP_MASK)) | perm_q) & ~IND_MASK | (cfg_q & IND_MASK);

   always_ff @(posedge clock) begin
      if (rst) begin
         load_q <= 1'b0;
         payload_q <= '0;
         len_q <= 6'h00;
         reply_ok_q <= 1'b0;
         go_arb_q <= 1'b0;
      end else begin
         load_q <= launch_ok || launch_err;
         go_arb_q <= state_q == ST_CHECK && frame_ok && to_arb;
         if (launch_ok) begin
            payload_q <= {HDR_OK, new_word, handle};
            len_q <= OK_REPLY_BITS;
            reply_ok_q <= 1'b1;
         end else if (launch_err) begin
            payload_q <= {HDR_ERR, ERR_CODE, handle, 8'h00};
            len_q <= ERR_REPLY_BITS;
            reply_ok_q <= 1'b0;
         end
      end
   end

   assign go_arbitrate = go_arb_q;

   // ***************************************
   // CRC engines and serializer
   // ***************************************
   rfct_crc16 u_rx_crc (
      .clock(clock),
      .rst(rst),
      .init(state_q == ST_IDLE),
      .en(state_q == ST_RECV && rx_bit_valid),
      .bit_in(rx_bit),
      .crc_q(rx_crc)
   );

   rfct_crc16 u_tx_crc (
      .clock(clock),
      .rst(rst),
      .init(load_q),
      .en(tx_feed),
      .bit_in(tx_bit),
      .crc_q(tx_crc)
   );

   rfct_tx_shift u_tx (
      .clock(clock),
      .rst(rst),
      .bit_en(bit_en),
      .load(load_q),
      .payload(payload_q),
      .len(len_q),
      .crc_in(tx_crc),
      .busy_q(tx_busy),
      .tx_bit_q(tx_bit),
      .tx_strobe_q(tx_strobe),
      .feed_q(tx_feed),
      .done_q(tx_done)
   );

   assign tx_active = tx_busy;
   assign tx_ext_preamble = tx_busy && reply_ok_q;
   assign tx_error = tx_busy && !reply_ok_q;

   // ***************************************
   // Checks
   // ***************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_ext_preamble: assert property (launch_ok |-> ##2 tx_ext_preamble)
      else $error("success reply without extended preamble");
   a_bad_crc_silent: assert property (state_q == ST_CHECK && !crc_ok
      |=> state_q == ST_IDLE ##1 !tx_active [*4])
      else $error("bad CRC command was not ignored");
   a_open_no_change: assert property (state_q == ST_CHECK && tag_state == TAG_OPEN
      && !std_wr && !nvm_load |=> $stable(temp_q) && $stable(perm_q))
      else $error("open state changed configuration");
   a_arb_return: assert property (state_q == ST_CHECK && frame_ok && to_arb
      |=> go_arbitrate ##1 !go_arbitrate)
      else $error("no return to arbitrate");
   a_ready_silent: assert property (state_q == ST_CHECK
      && (tag_state == TAG_READY || tag_state == TAG_KILLED)
      |=> state_q == ST_IDLE && !go_arbitrate)
      else $error("ready or killed tag acted on command");
   a_rfu_discard: assert property (state_q == ST_CHECK && rfu_hit
      |=> state_q == ST_IDLE && !store_req_q)
      else $error("reserved toggle not discarded");
   a_temp_cleared: assert property ($past(rst) |-> temp_q == CFG_RESET)
      else $error("temporary bits not cleared at reset");
   a_store_first: assert property (state_q == ST_STORE |-> !tx_active && !load_q)
      else $error("reply sent before store finished");
   a_locked_write: assert property (mem_wr_en && epc_locked && state_q == ST_IDLE
      && !nvm_load |=> $stable(perm_q))
      else $error("locked bank accepted standard write");
   a_no_fsync: assert property (state_q == ST_CHECK && !fsync_q
      |=> state_q == ST_IDLE && !go_arbitrate)
      else $error("command without frame-sync accepted");

   c_toggle_store: cover property (state_q == ST_STORE ##[1:1000] tx_ext_preamble);
   c_error_reply: cover property (tx_error);
   c_arbitrate: cover property (go_arbitrate);
endmodule : rfct_toggle

// file: rfct_pkg.sv
// Package: constants and types for the feature-configuration toggle command block
package rfct_pkg;
   // ***************************************
   // Command frame
   // ***************************************
   localparam logic [15:0] CMD_CODE = 16'hE007;
   localparam int CMD_BITS = 72;
   localparam int OPC_LSB = 56;
   localparam int RFU_LSB = 48;
   localparam int DATA_LSB = 32;
   localparam int HANDLE_LSB = 16;
   localparam logic [6:0] CMD_BITS_W = 7'h48;
   // ***************************************
   // CRC-16
   // ***************************************
   localparam logic [15:0] CRC_PRESET = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_RESIDUE = 16'h1D0F;
   // ***************************************
   // Configuration word, bit n sits at data bit 15-n
   // ***************************************
   localparam logic [11:0] CFG_BIT_ADDR = 12'h200;
   localparam logic [15:0] IND_MASK = 16'hC000;
   localparam logic [15:0] RFU_MASK = 16'h3000;
   localparam logic [15:0] TEMP_MASK = 16'h0E00;
   localparam logic [15:0] PERM_MASK = 16'h01FF;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam int TAMPER_POS = 15;
   localparam int SUPPLY_POS = 14;
   // ***************************************
   // Reply
   // ***************************************
   localparam int PAYLOAD_W = 33;
   localparam logic [5:0] OK_REPLY_BITS = 6'h21;
   localparam logic [5:0] ERR_REPLY_BITS = 6'h19;
   localparam logic HDR_OK = 1'b0;
   localparam logic HDR_ERR = 1'b1;
   // ***************************************
   // Timing
   // ***************************************
   localparam int CLK_MHZ = 200;
   localparam int REPLY_LIMIT_MS = 20;
   localparam int REPLY_LIMIT_CYC = REPLY_LIMIT_MS * CLK_MHZ * 1000;
   localparam int LINK_KHZ = 160;
   localparam int BIT_CYC = CLK_MHZ * 1000 / LINK_KHZ;
   // ***************************************
   // Types
   // ***************************************
   typedef enum logic [2:0] {
      TAG_READY = 3'b000,
      TAG_ARBITRATE = 3'b001,
      TAG_REPLY = 3'b010,
      TAG_ACKNOWLEDGED = 3'b011,
      TAG_OPEN = 3'b100,
      TAG_SECURED = 3'b101,
      TAG_KILLED = 3'b110
   } rfct_tag_state_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_CHECK = 3'b010,
      ST_STORE = 3'b011,
      ST_REPLY = 3'b100
   } rfct_fsm_type;
endpackage : rfct_pkg

// file: rfct_crc16.sv
// Serial CRC-16 register, one bit per enable
module rfct_crc16
   import rfct_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic init,
   input wire logic en,
   input wire logic bit_in,
   output logic [15:0] crc_q
);
   logic feedback;
   logic [15:0] crc_d;

   assign feedback = crc_q[15] ^ bit_in;
   assign crc_d = {crc_q[14:0], 1'b0} ^ (feedback ? CRC_POLY : 16'h0000);

   always_ff @(posedge clock) begin
      if (rst || init) begin
         crc_q <= CRC_PRESET;
      end else if (en) begin
         crc_q <= crc_d;
      end
   end
endmodule : rfct_crc16

// file: rfct_tx_shift.sv
// Reply serializer: payload bits, then the inverted CRC
module rfct_tx_shift
   import rfct_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic bit_en,
   input wire logic load,
   input wire logic [PAYLOAD_W-1:0] payload,
   input wire logic [5:0] len,
   input wire logic [15:0] crc_in,
   output logic busy_q,
   output logic tx_bit_q,
   output logic tx_strobe_q,
   output logic feed_q,
   output logic done_q
);
   logic [PAYLOAD_W-1:0] sr_q;
   logic [5:0] cnt_q;
   logic crc_phase_q;

   always_ff @(posedge clock) begin
      tx_strobe_q <= 1'b0;
      feed_q <= 1'b0;
      done_q <= 1'b0;
      if (rst) begin
         busy_q <= 1'b0;
         tx_bit_q <= 1'b0;
         sr_q <= '0;
         cnt_q <= 6'h00;
         crc_phase_q <= 1'b0;
      end else if (load) begin
         busy_q <= 1'b1;
         sr_q <= payload;
         cnt_q <= len;
         crc_phase_q <= 1'b0;
      end else if (busy_q && bit_en) begin
         if (cnt_q != 6'h00) begin
            tx_bit_q <= sr_q[PAYLOAD_W-1];
            sr_q <= {sr_q[PAYLOAD_W-2:0], 1'b0};
            cnt_q <= cnt_q - 6'h01;
            tx_strobe_q <= 1'b1;
            feed_q <= ~crc_phase_q;
         end else if (!crc_phase_q) begin
            // CRC is settled: last payload bit went in at least one cycle ago
            tx_bit_q <= ~crc_in[15];
            sr_q <= {~crc_in[14:0], 18'h00000};
            cnt_q <= 6'h0F;
            crc_phase_q <= 1'b1;
            tx_strobe_q <= 1'b1;
         end else begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end
      end
   end
endmodule : rfct_tx_shift

// file: rfct_reader_model.sv
// Interrogator model: sends toggle command frames and captures the replies
module rfct_reader_model
   import rfct_pkg::*;
(
   input wire logic clock,
   input wire logic tx_bit,
   input wire logic tx_strobe,
   output logic rx_frame_start,
   output logic rx_frame_sync,
   output logic rx_bit,
   output logic rx_bit_valid,
   output logic rx_frame_end
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [48:0] reply_q;
   int n_bits;
   initial begin
      rx_frame_start = 1'b0;
      rx_frame_sync = 1'b0;
      rx_bit = 1'b0;
      rx_bit_valid = 1'b0;
      rx_frame_end = 1'b0;
      reply_q = '0;
      n_bits = 0;
   end
   always @(posedge clock) begin
      if (tx_strobe) begin
         reply_q <= {reply_q[47:0], tx_bit};
         n_bits <= n_bits + 1;
      end
   end
   function automatic logic [15:0] crc_over(input logic [55:0] v, input int n);
      logic [15:0] c;
      c = CRC_PRESET;
      for (int i = n - 1; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction : crc_over
   // Idle data line shows the inverse of the last bit, never a stale copy
   task automatic send(input logic [55:0] body, input logic fsync, input logic bad);
      logic [71:0] frame;
      frame = {body, ~crc_over(body, 56) ^ {15'h0000, bad}};
      n_bits = 0;
      @(posedge clock);
      #1;
      rx_frame_start = 1'b1;
      rx_frame_sync = fsync;
      @(posedge clock);
      #1;
      rx_frame_start = 1'b0;
      rx_frame_sync = ~fsync;
      for (int i = 71; i >= 0; i--) begin
         rx_bit = frame[i];
         rx_bit_valid = 1'b1;
         @(posedge clock);
         #1;
         rx_bit_valid = 1'b0;
         rx_bit = ~frame[i];
         @(posedge clock);
         #1;
      end
      rx_frame_end = 1'b1;
      @(posedge clock);
      #1;
      rx_frame_end = 1'b0;
   endtask : send
endmodule : rfct_reader_model

// file: tb_top.sv
// Self-checking bench for the feature toggle command block
module tb_top
   import rfct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ERR_VAL = 8'h3C;
   logic clock, rst, rx_frame_start, rx_frame_sync, rx_bit, rx_bit_valid, rx_frame_end;
   logic handle_granted, access_pwd_zero, epc_locked, tamper_in, ext_supply_in, nvm_load;
   logic mem_wr_en, nvm_store_done, nvm_store_fail, nvm_store_req, go_arbitrate, fail_mode;
   logic tx_bit, tx_strobe, tx_active, tx_ext_preamble, tx_error, mute_mode;
   logic [15:0] handle, rn16, nvm_word, mem_wr_data, nvm_store_data, cfg_word, exp_bits, lfsr_q;
   logic [11:0] mem_wr_addr;
   rfct_tag_state_type tag_state;
   rfct_tag_state_type sts[5] = '{TAG_READY, TAG_ARBITRATE, TAG_REPLY, TAG_ACKNOWLEDGED,
      TAG_KILLED};
   int err_count, checks;
   rfct_toggle #(.REPLY_LIMIT(50), .BIT_PERIOD(4), .ERR_CODE(ERR_VAL)) u_dut (.clock, .rst,
      .rx_frame_start, .rx_frame_sync, .rx_bit, .rx_bit_valid, .rx_frame_end, .tag_state,
      .handle_granted, .handle, .rn16, .access_pwd_zero, .epc_locked, .tamper_in,
      .ext_supply_in, .nvm_load, .nvm_word, .mem_wr_en, .mem_wr_addr, .mem_wr_data,
      .nvm_store_done, .nvm_store_fail, .nvm_store_req, .nvm_store_data, .go_arbitrate,
      .tx_bit, .tx_strobe, .tx_active, .tx_ext_preamble, .tx_error, .cfg_word);
   rfct_reader_model u_rdr (.clock, .tx_bit, .tx_strobe, .rx_frame_start, .rx_frame_sync,
      .rx_bit, .rx_bit_valid, .rx_frame_end);
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Memory answers each store one cycle later, or never when failing and muted
   always @(posedge clock) begin
      nvm_store_done <= nvm_store_req & ~fail_mode;
      nvm_store_fail <= nvm_store_req & fail_mode & ~mute_mode;
   end
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check
   task automatic wrap_up();
      $display("Mismatches %0d, checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   function automatic logic [15:0] full(input logic [15:0] b);
      return {tamper_in, ext_supply_in, 2'b00, b[11:0]};
   endfunction : full
   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : nxt
   // ***************************************
   // Command with reply bookkeeping
   // ***************************************
   task automatic do_cmd(input rfct_tag_state_type st, input logic [15:0] mask, input int flt);
      logic rep, act, seen, ext, err, garb;
      logic [15:0] hd;
      rep = (st == TAG_OPEN || st == TAG_SECURED) && flt == 0 && (mask & RFU_MASK) == 16'h0000;
      act = rep && st == TAG_SECURED && !access_pwd_zero;
      seen = 1'b0;
      ext = 1'b0;
      err = 1'b0;
      garb = 1'b0;
      tag_state = st;
      handle_granted = (flt != 4);
      hd = (flt == 3) ? handle ^ 16'h0001 : handle;
      u_rdr.send({CMD_CODE, 8'h00, mask ^ rn16, hd}, flt != 2, flt == 1);
      for (int i = 0; i < 400; i++) begin
         @(posedge clock);
         #1;
         garb |= go_arbitrate;
         if (tx_active) begin
            seen = 1'b1;
            ext |= tx_ext_preamble;
            err |= tx_error;
         end else if (seen) begin
            break;
         end
      end
      check(tx_active === 1'b0, "reply did not end");
      if (tx_active !== 1'b0) wrap_up();
      check(seen === rep, "reply presence");
      check(garb === (st inside {TAG_ARBITRATE, TAG_REPLY, TAG_ACKNOWLEDGED}), "arb");
      if (rep && fail_mode) begin
         check(err && !ext && u_rdr.n_bits == 41, "error reply form");
         check(u_rdr.reply_q[40:16] === {HDR_ERR, ERR_VAL, handle}, "error fields");
      end else if (rep) begin
         if (act) exp_bits = exp_bits ^ (mask & (TEMP_MASK | PERM_MASK));
         if (act && (mask & PERM_MASK) != 16'h0000) begin
            check(nvm_store_data === (exp_bits & PERM_MASK), "store data");
         end
         check(ext && !err && u_rdr.n_bits == 49, "reply form");
         check(u_rdr.reply_q[48:16] === {HDR_OK, full(exp_bits), handle}, "fields");
         check(u_rdr.reply_q[15:0] === ~u_rdr.crc_over({23'h0, HDR_OK, full(exp_bits), handle},
            33), "reply crc");
      end
      check(cfg_word === full(exp_bits), "word after command");
   endtask : do_cmd
   task automatic std_write(input logic [11:0] a, input logic [15:0] d, input logic lk);
      epc_locked = lk;
      mem_wr_addr = a;
      mem_wr_data = d;
      mem_wr_en = 1'b1;
      @(posedge clock);
      #1;
      mem_wr_en = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      if (!lk && a == CFG_BIT_ADDR) exp_bits = d & (TEMP_MASK | PERM_MASK);
      check(cfg_word === full(exp_bits), "standard write");
      epc_locked = 1'b1;
   endtask : std_write
   initial begin
      err_count = 0;
      checks = 0;
      {rst, tamper_in, epc_locked, handle_granted} = 4'hF;
      {access_pwd_zero, ext_supply_in, nvm_load, mem_wr_en, fail_mode, mute_mode} = 6'h00;
      {mem_wr_addr, mem_wr_data} = '0;
      tag_state = TAG_SECURED;
      lfsr_q = 16'h50F2;
      handle = 16'h5A3C;
      rn16 = nxt(lfsr_q);
      nvm_word = nxt(rn16);
      repeat (12) @(posedge clock);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      exp_bits = 16'h0000;
      check(cfg_word === full(16'h0000), "power-up word");
      nvm_load = 1'b1;
      @(posedge clock);
      #1;
      nvm_load = 1'b0;
      exp_bits = nvm_word & PERM_MASK;
      do_cmd(TAG_SECURED, 16'h0E00, 0);
      do_cmd(TAG_SECURED, 16'h0011, 0);
      do_cmd(TAG_SECURED, 16'h0011, 0);
      do_cmd(TAG_SECURED, 16'hC000, 0);
      do_cmd(TAG_SECURED, 16'h1000, 0);
      do_cmd(TAG_OPEN, 16'h0101, 0);
      for (int f = 1; f <= 4; f++) do_cmd(TAG_SECURED, 16'h0003, f);
      access_pwd_zero = 1'b1;
      do_cmd(TAG_SECURED, 16'h0003, 0);
      access_pwd_zero = 1'b0;
      foreach (sts[s]) do_cmd(sts[s], 16'h0003, 0);
      fail_mode = 1'b1;
      // Second pass leaves the store unanswered so the timeout path is taken
      for (int m = 0; m < 2; m++) begin
         mute_mode = m[0];
         do_cmd(TAG_SECURED, 16'h0040, 0);
      end
      mute_mode = 1'b0;
      fail_mode = 1'b0;
      for (int k = 0; k < 8; k++) begin
         lfsr_q = nxt(nxt(lfsr_q));
         rn16 = lfsr_q;
         handle = nxt(lfsr_q);
         lfsr_q = nxt(handle);
         {tamper_in, ext_supply_in} = lfsr_q[9:8];
         do_cmd(TAG_SECURED, lfsr_q & ~RFU_MASK, 0);
      end
      std_write(CFG_BIT_ADDR, nxt(lfsr_q), 1'b0);
      std_write(CFG_BIT_ADDR, ~lfsr_q, 1'b1);
      std_write(12'h210, lfsr_q, 1'b0);
      wrap_up();
   end
endmodule : tb_top
